/* File: pkg/sbs_map.vh */
// Constants of the synchronous burst SRAM control block
`ifndef SBS_MAP_VH
`define SBS_MAP_VH
`define SBS_LANES 4
`define SBS_LANE_W 9
`define SBS_ADDR_W 10
`define SBS_DEPTH 1024
`define SBS_BURST_W 2
`define SBS_BURST_WRAP 2'h3
`define SBS_DQ_RESET 36'h000000000
`define SBS_PIPE_STAGES 1
`endif

/* File: rtl/sbs_burst_ctr.v */
// Two-bit burst address counter, linear or interleaved
`timescale 1ns/1ps
`include "sbs_map.vh"
module sbs_burst_ctr (
    input wire i_clk_sys,
    input wire i_rst_n,
    input wire i_load,
    input wire i_step,
    input wire i_interleave,
    input wire [`SBS_BURST_W-1:0] i_start,
    output wire [`SBS_BURST_W-1:0] o_addr
);
    reg [`SBS_BURST_W-1:0] start_reg;
    reg [`SBS_BURST_W-1:0] count_reg;
    // ----------------------------------------
    // Counter
    // ----------------------------------------
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            start_reg <= 2'h0;
            count_reg <= 2'h0;
        end else if (i_load) begin
            start_reg <= i_start;
            count_reg <= 2'h0;
        end else if (i_step) begin
            count_reg <= count_reg + 2'h1; // Wraps to start on 5th clock
        end
    end
    assign o_addr = i_interleave ? (start_reg ^ count_reg) :
                    (start_reg + count_reg);
endmodule // sbs_burst_ctr

/* File: rtl/sbs_lane_dec.v */
// Byte lane write decode
`timescale 1ns/1ps
`include "sbs_map.vh"
module sbs_lane_dec (
    input wire i_global_write_n,
    input wire i_byte_write_gate_n,
    input wire [`SBS_LANES-1:0] i_lane_write_en_n,
    input wire i_wide,
    output wire o_is_write,
    output wire [`SBS_LANES-1:0] o_lane_we
);
    wire [`SBS_LANES-1:0] present;
    assign present = i_wide ? 4'hF : 4'h3;
    assign o_is_write = !i_global_write_n || !i_byte_write_gate_n;
    assign o_lane_we = !i_global_write_n ? present :
                       (!i_byte_write_gate_n ? (~i_lane_write_en_n & present) :
                       4'h0);
endmodule // sbs_lane_dec

/* File: rtl/sbs_sram_ctrl.v */
// Synchronous burst SRAM control with mode pins and byte writes
// Summary of operation
// - Burst order select low linear, high interleaved
// - Flow-through select low bypasses output register
// - Sleep request high puts device in standby
// - Deselect select low dual, high single cycle; drivers go off at the same edge in both
// - Unconnected mode pins take documented defaults
// - Low two address bits preset burst counter
// - Linear order adds count modulo four
// - Interleaved order XORs count onto start
// - Counter advances only when step is low
// - Either address strobe loads address, begins burst
// - Global write low writes every lane
// - Both write inputs high means read
// - Byte gate low with global write high writes enabled lanes only
// - Each byte enable maps to own lane
// - Data outputs stay off during writes
// - Lanes c and d only when wide
// - No strobe: step advances, else holds address
// - Output enable high turns drivers off at once
// - Dummy read advances counter like normal read
`timescale 1ns/1ps
`include "sbs_map.vh"
module sbs_sram_ctrl (
    input wire i_clk_sys,
    input wire i_rst_n,
    input wire i_burst_order_sel_n,
    input wire i_flow_through_select_n,
    input wire i_flow_through_select_nc,
    input wire i_sleep_request,
    input wire i_sleep_request_nc,
    input wire i_deselect_latency_sel,
    input wire i_deselect_latency_sel_nc,
    input wire i_drive_select,
    input wire i_drive_select_nc,
    input wire i_wide,
    input wire i_chip_select_n,
    input wire i_chip_enable_hi,
    input wire i_chip_enable2_n,
    input wire i_processor_addr_strobe_n,
    input wire i_controller_addr_strobe_n,
    input wire i_burst_step_n,
    input wire i_global_write_n,
    input wire i_byte_write_gate_n,
    input wire i_lane_a_write_en_n,
    input wire i_lane_b_write_en_n,
    input wire i_lane_c_write_en_n,
    input wire i_lane_d_write_en_n,
    input wire i_output_enable_n,
    input wire [`SBS_ADDR_W-1:0] i_addr,
    input wire [`SBS_LANES*`SBS_LANE_W-1:0] i_dq,
    output wire [`SBS_LANES*`SBS_LANE_W-1:0] o_dq,
    output wire [`SBS_LANES-1:0] o_dq_oe,
    output wire o_standby,
    output wire o_high_drive
);
    // ----------------------------------------
    // Mode pins with pull defaults
    // ----------------------------------------
    // Modes sampled live; changing them mid-burst is unsupported
    wire pipelined;
    wire dcd_mode;
    wire sleep_async;
    assign pipelined = i_flow_through_select_nc ? 1'b1 : i_flow_through_select_n;
    assign dcd_mode = i_deselect_latency_sel_nc ? 1'b0 : !i_deselect_latency_sel;
    assign sleep_async = i_sleep_request_nc ? 1'b0 : i_sleep_request;
    assign o_high_drive = i_drive_select_nc ? 1'b0 : !i_drive_select;

    // Sleep is asynchronous: three stages, accepted when last two agree
    reg [2:0] sleep_sync_reg;
    reg sleep_reg;
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sleep_sync_reg <= 3'h0;
            sleep_reg <= 1'b0;
        end else begin
            sleep_sync_reg <= {sleep_sync_reg[1:0], sleep_async};
            if (sleep_sync_reg[2] == sleep_sync_reg[1])
                sleep_reg <= sleep_sync_reg[2];
        end
    end
    assign o_standby = sleep_reg;

    // ----------------------------------------
    // Cycle decode
    // ----------------------------------------
    wire enabled;
    wire processor_addr_strobe_n;
    wire controller_addr_strobe_n;
    wire ext_load;
    wire deselect;
    wire cont;
    wire active;
    wire is_write;
    wire [`SBS_LANES-1:0] lane_we;
    wire [`SBS_BURST_W-1:0] burst_addr;
    assign enabled = i_chip_enable_hi && !i_chip_select_n && !i_chip_enable2_n;
    assign processor_addr_strobe_n = !i_processor_addr_strobe_n;
    assign controller_addr_strobe_n = !i_controller_addr_strobe_n;
    // Processor strobe is ignored while the chip select is high
    assign ext_load = !sleep_reg && enabled && (processor_addr_strobe_n || controller_addr_strobe_n);
    assign deselect = !sleep_reg && !enabled && (controller_addr_strobe_n || (processor_addr_strobe_n && !i_chip_select_n));
    assign cont = !sleep_reg && !controller_addr_strobe_n && !(processor_addr_strobe_n && !i_chip_select_n);
    assign active = ext_load || cont;

    sbs_lane_dec u_lane_dec (
        .i_global_write_n(i_global_write_n),
        .i_byte_write_gate_n(i_byte_write_gate_n),
        .i_lane_write_en_n({i_lane_d_write_en_n, i_lane_c_write_en_n,
                            i_lane_b_write_en_n, i_lane_a_write_en_n}),
        .i_wide(i_wide),
        .o_is_write(is_write),
        .o_lane_we(lane_we)
    );

    // Processor strobe load is always a read
    wire do_write;
    assign do_write = active && is_write && !(ext_load && processor_addr_strobe_n);

    // Step regardless of output enable, so dummy reads advance too
    sbs_burst_ctr u_ctr (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_load(ext_load),
        .i_step(cont && !i_burst_step_n),
        .i_interleave(i_burst_order_sel_n),
        .i_start(i_addr[`SBS_BURST_W-1:0]),
        .o_addr(burst_addr)
    );

    // ----------------------------------------
    // Address register and array
    // ----------------------------------------
    reg [`SBS_ADDR_W-1:0] base_reg;
    reg [`SBS_LANES*`SBS_LANE_W-1:0] mem [0:`SBS_DEPTH-1];
    wire [`SBS_ADDR_W-1:0] cur_addr;
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n)
            base_reg <= 10'h000;
        else if (ext_load)
            base_reg <= i_addr;
    end
    assign cur_addr = {base_reg[`SBS_ADDR_W-1:`SBS_BURST_W], burst_addr};

    // Late write: data for a write cycle follows on the next edge
    reg wr_pend_reg;
    reg [`SBS_LANES-1:0] wr_lane_reg;
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_pend_reg <= 1'b0;
            wr_lane_reg <= 4'h0;
        end else begin
            wr_pend_reg <= do_write;
            wr_lane_reg <= lane_we;
        end
    end

    genvar g;
    generate
        for (g = 0; g < `SBS_LANES; g = g + 1) begin : g_lane
            always @(posedge i_clk_sys) begin
                if (wr_pend_reg && wr_lane_reg[g])
                    mem[cur_addr][g*`SBS_LANE_W +: `SBS_LANE_W] <=
                        i_dq[g*`SBS_LANE_W +: `SBS_LANE_W];
            end
        end
    endgenerate

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    reg [`SBS_LANES*`SBS_LANE_W-1:0] ft_data_reg;
    reg [`SBS_LANES*`SBS_LANE_W-1:0] pl_data_reg;
    reg ft_valid_reg;
    reg pl_valid_reg;
    reg dcd_hold_reg;
    wire read_cyc;
    assign read_cyc = active && !do_write;
    // Continue cycle with step reads the next word, not the current one
    wire [`SBS_BURST_W-1:0] cnt_now;
    wire [`SBS_BURST_W-1:0] cnt_up;
    wire [`SBS_BURST_W-1:0] step_addr;
    wire [`SBS_ADDR_W-1:0] rd_addr;
    assign cnt_now = i_burst_order_sel_n ? (burst_addr ^ base_reg[1:0]) :
                     (burst_addr - base_reg[1:0]);
    assign cnt_up = cnt_now + 2'h1;
    assign step_addr = i_burst_order_sel_n ? (base_reg[1:0] ^ cnt_up) :
                       (base_reg[1:0] + cnt_up);
    assign rd_addr = {base_reg[`SBS_ADDR_W-1:`SBS_BURST_W],
                      (cont && !i_burst_step_n) ? step_addr : burst_addr};
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ft_data_reg <= `SBS_DQ_RESET;
            pl_data_reg <= `SBS_DQ_RESET;
            ft_valid_reg <= 1'b0;
            pl_valid_reg <= 1'b0;
            dcd_hold_reg <= 1'b0;
        end else begin
            ft_valid_reg <= read_cyc;
            if (read_cyc)
                ft_data_reg <= mem[ext_load ? i_addr : rd_addr];
            pl_data_reg <= ft_data_reg;
            // Dual deselect hold is set only when pl_valid_reg is, so it adds no driver cycle after deselect
            pl_valid_reg <= ft_valid_reg;
            dcd_hold_reg <= dcd_mode && deselect && ft_valid_reg;
        end
    end

    wire drive_on;
    wire [`SBS_LANES-1:0] present;
    assign present = i_wide ? 4'hF : 4'h3;
    assign drive_on = pipelined ? (pl_valid_reg || dcd_hold_reg) : ft_valid_reg;
    // Output enable is combinational so high kills drivers at once
    assign o_dq_oe = (drive_on && !i_output_enable_n && !sleep_reg && !wr_pend_reg) ?
                     present : 4'h0;
    assign o_dq = pipelined ? pl_data_reg : ft_data_reg;
endmodule // sbs_sram_ctrl

/* File: tb/sbs_host_model.sv */
// Cache controller side model presenting late write data
`timescale 1ns/1ps
module sbs_host_model (
    input wire i_clk_sys,
    input wire i_valid,
    input wire [35:0] i_data,
    output reg [35:0] o_dq = 36'h000000000
);
    // Released bus toggles so stale data never passes for a write
    always @(posedge i_clk_sys) o_dq <= i_valid ? i_data : ~o_dq;
endmodule // sbs_host_model

/* File: tb/sbs_sram_ctrl_assertions.sv */
// Port checks for the burst SRAM control block
`timescale 1ns/1ps
module sbs_sram_ctrl_chk (
    input wire i_clk_sys,
    input wire i_rst_n,
    input wire i_flow_through_select_n,
    input wire i_flow_through_select_nc,
    input wire i_sleep_request,
    input wire i_sleep_request_nc,
    input wire i_drive_select,
    input wire i_drive_select_nc,
    input wire i_wide,
    input wire i_chip_select_n,
    input wire i_chip_enable_hi,
    input wire i_chip_enable2_n,
    input wire i_processor_addr_strobe_n,
    input wire i_controller_addr_strobe_n,
    input wire i_global_write_n,
    input wire i_byte_write_gate_n,
    input wire i_output_enable_n,
    input wire [3:0] o_dq_oe,
    input wire o_standby,
    input wire o_high_drive
);
    wire en = i_chip_enable_hi && !i_chip_select_n && !i_chip_enable2_n;
    wire ld = en && !i_controller_addr_strobe_n && i_processor_addr_strobe_n;
    wire rd = ld && i_global_write_n && i_byte_write_gate_n && !i_output_enable_n && !o_standby;
    wire ft = !i_flow_through_select_n && !i_flow_through_select_nc;
    wire [3:0] full = i_wide ? 4'hF : 4'h3;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    sequence s_rd_pipe;
        rd && !ft ##1 !i_output_enable_n;
    endsequence
    a_ft_read_lanes: assert property (rd && ft |=> i_output_enable_n || o_dq_oe == full)
        else $error("flow read lanes off");
    a_pipe_read_late: assert property (s_rd_pipe |=> i_output_enable_n || o_dq_oe == full)
        else $error("pipelined read lanes off");
    a_oe_forces_off: assert property (i_output_enable_n |-> o_dq_oe == 4'h0)
        else $error("drivers on with oe high");
    a_write_quiet: assert property (ld && !i_global_write_n && ft && !i_output_enable_n
        && o_dq_oe == 4'h0 |=> o_dq_oe == 4'h0)
        else $error("drivers on in write");
    a_deselect_quiet: assert property ((!en && !i_controller_addr_strobe_n) [*3] |-> !o_dq_oe)
        else $error("drivers on when deselected");
    a_sleep_enter: assert property ((i_sleep_request && !i_sleep_request_nc) [*5] |-> o_standby)
        else $error("no standby");
    a_sleep_default: assert property (i_sleep_request_nc [*5] |-> !o_standby)
        else $error("floating sleep gave standby");
    a_drive_default: assert property (o_high_drive == (!i_drive_select && !i_drive_select_nc))
        else $error("drive select wrong");
endmodule // sbs_sram_ctrl_chk
bind sbs_sram_ctrl sbs_sram_ctrl_chk u_chk (.*);

/* File: tb/tb_top.sv */
// Self-checking bench for the burst SRAM control block
`timescale 1ns/1ps
module tb_top;
    logic i_clk_sys = 0, i_rst_n = 0, i_burst_order_sel_n = 0, i_flow_through_select_n = 0;
    logic i_flow_through_select_nc = 0, i_sleep_request = 0, i_sleep_request_nc = 0;
    logic i_deselect_latency_sel = 1, i_deselect_latency_sel_nc = 0, i_drive_select = 1;
    logic i_drive_select_nc = 0, i_wide = 1, i_chip_select_n = 0, i_chip_enable_hi = 0;
    logic i_chip_enable2_n = 0, i_processor_addr_strobe_n = 1, i_controller_addr_strobe_n = 0;
    logic i_burst_step_n = 1, i_global_write_n = 1, i_byte_write_gate_n = 1, i_output_enable_n = 0;
    logic hv = 0;
    logic [3:0] ln = 4'hF, o_dq_oe;
    logic [9:0] i_addr = 10'h000;
    logic [35:0] hd = 36'h0, i_dq, o_dq, e[5];
    logic o_standby, o_high_drive;
    wire i_lane_a_write_en_n = ln[0];
    wire i_lane_b_write_en_n = ln[1];
    wire i_lane_c_write_en_n = ln[2];
    wire i_lane_d_write_en_n = ln[3];
    int n_fail = 0, check_count = 0;
    initial forever #2.5 i_clk_sys = ~i_clk_sys;
    sbs_host_model host (.i_clk_sys(i_clk_sys), .i_valid(hv), .i_data(hd), .o_dq(i_dq));
    sbs_sram_ctrl uut (.*);
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
            n_fail++;
        end
    endtask
    // Write data follows one cycle after the command
    task automatic wr(input [9:0] a, input [35:0] d, input g, input b, input [3:0] l);
        @(posedge i_clk_sys);
        i_chip_enable_hi <= 1;
        {i_global_write_n, i_byte_write_gate_n, ln, i_addr, hv, hd} <= {g, b, l, a, 1'b1, d};
        @(posedge i_clk_sys);
        {i_chip_enable_hi, i_global_write_n, i_byte_write_gate_n, hv} <= 4'hE;
    endtask
    task automatic rd(input [9:0] a, input int n, input int lat, input bit sp);
        for (int k = 0; k < n + lat; k++) begin
            @(posedge i_clk_sys);
            i_chip_enable_hi <= k < n;
            i_processor_addr_strobe_n <= !(k == 0 && sp);
            i_controller_addr_strobe_n <= k == 0 ? sp : k < n;
            i_burst_step_n <= k == 0;
            i_addr <= a;
            @(negedge i_clk_sys);
            if (k >= lat) begin
                chk(o_dq, e[k - lat]);
                chk({32'h0, o_dq_oe}, 36'hF);
            end
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_lanes;
        wr(10'h010, 36'h123456789, 1'b0, 1'b1, 4'hF);
        wr(10'h010, 36'hFEDCBA987, 1'b1, 1'b0, 4'hA);
        wr(10'h010, 36'h0, 1'b1, 1'b0, 4'hF);
        e[0] = (36'hFEDCBA987 & 36'h007FC01FF) | (36'h123456789 & ~36'h007FC01FF);
        rd(10'h010, 1, 1, 1'b0);
        wr(10'h010, 36'h055555555, 1'b0, 1'b0, 4'hF);
        e[0] = 36'h055555555;
        rd(10'h010, 1, 1, 1'b1);
        $display("lanes done");
    endtask
    task automatic t_burst;
        for (int i = 0; i < 4; i++) wr(10'(32 + i), 36'(256 + i), 1'b0, 1'b1, 4'hF);
        for (int o = 0; o < 2; o++) begin
            @(posedge i_clk_sys);
            i_burst_order_sel_n <= o[0];
            for (int k = 0; k < 5; k++) e[k] = 36'(256 + (o ? (1 ^ k) & 3 : (1 + k) & 3));
            rd(10'h021, 5, 1, o[0]);
        end
        $display("burst done");
    endtask
    task automatic t_pipe;
        @(posedge i_clk_sys);
        {i_flow_through_select_n, i_deselect_latency_sel} <= 2'b10;
        e[0] = 36'h055555555;
        rd(10'h010, 1, 2, 1'b0);
        @(posedge i_clk_sys);
        {i_flow_through_select_n, i_deselect_latency_sel} <= 2'b01;
        $display("pipe done");
    endtask
    task automatic t_sleep;
        @(posedge i_clk_sys);
        {i_sleep_request, i_output_enable_n, i_drive_select_nc} <= 3'h7;
        repeat (6) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        chk({35'h0, o_standby}, 36'h1);
        chk({35'h0, o_high_drive}, 36'h0);
        @(posedge i_clk_sys);
        {i_sleep_request_nc, i_drive_select_nc, i_drive_select} <= 3'h4;
        repeat (6) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        chk({35'h0, o_standby}, 36'h0);
        chk({35'h0, o_high_drive}, 36'h1);
        @(posedge i_clk_sys);
        {i_sleep_request, i_sleep_request_nc, i_output_enable_n, i_drive_select} <= 4'h1;
        $display("sleep done");
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #100000;
        n_fail++;
        end_sim;
    end
    initial begin
        repeat (20) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        t_lanes;
        t_burst;
        t_pipe;
        t_sleep;
        end_sim;
    end
endmodule // tb_top
